//--- hdl/disk_buffer_manager_control.sv
// Buffer manager control and status registers with pointer and strobe logic.
//
// The Wishbone interface to the registers was decided locally.
`default_nettype none
// Operation
// - strobe suppress holds output strobe high
// - select bit picks master or slave role
// - diagnostic: both answer, only master reports
// - mode bit turns pin into chip select
// - gate lets host bit enable DMA
// - status bit mirrors host DMA enable bit
// - stop compare off until stop high written
// - transfer control clears on three resets
// - dual chip mode adds second chip enable
// - start launches transfer in programmed direction
// - done flag when host pointer hits stop
// - disk direction bit steers formatter data
// - chip enable control holds chip select
// - output enable control asserts output strobe
// - demand mode holds request whole transfer
// - shadow register reached via select, clears
// - overlay and select steer address map
// - refresh disable stops automatic refresh
// - fixed segments wrap within segment
// - variable segment reloads start at end
module disk_buffer_manager_control
	import buf_ctl_pkg::*;
(
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic             wb_cyc_in,
	input  wire logic             wb_stb_in,
	input  wire logic             wb_we_in,
	input  wire logic [9:0]       wb_adr_in,
	input  wire logic [3:0]       wb_sel_in,
	input  wire logic [31:0]      wb_dat_in,
	output logic      [31:0]      wb_dat_out,
	output logic                  wb_ack_out,
	input  wire logic             host_reset_input,
	input  wire logic             bm_reset_in,
	input  wire logic             fixed_disk_dma_bit_in,
	input  wire logic             host_drive_select_in,
	input  wire logic             host_diag_command_in,
	input  wire logic             host_auto_command_in,
	input  wire logic             host_step_in,
	input  wire logic             host_stall_in,
	input  wire logic             disk_step_in,
	input  wire logic             uc_buffer_access_in,
	input  wire logic             buffer_read_in,
	input  wire logic             buffer_addr15_in,
	input  wire logic             stop_high_write_in,
	input  wire logic [PTR_W-1:0] stop_pointer_in,
	input  wire logic [PTR_W-1:0] buffer_start_in,
	input  wire logic [PTR_W-1:0] buffer_end_in,
	output logic                  buffer_output_strobe_n_out,
	output logic                  buffer_chip_select_n_out,
	output logic                  second_buffer_chip_select_n_out,
	output logic                  dram_cycle_skip_out,
	output logic                  dram_refresh_enable_out,
	output logic                  buffer_parity_enable_out,
	output logic                  device_selected_out,
	output logic                  status_report_enable_out,
	output logic                  host_second_chip_select_mode_out,
	output logic                  host_dma_channel_enable_out,
	output logic                  host_dma_request_out,
	output logic                  host_dir_to_host_out,
	output logic                  disk_dir_to_buffer_out,
	output logic                  transfer_done_out,
	output logic                  bm_low_window_out,
	output logic                  bm_high_window_out,
	output logic                  control_store_window_out,
	output logic [PTR_W-1:0]      host_buffer_pointer_out,
	output logic [PTR_W-1:0]      disk_buffer_pointer_out
);
	logic [1:0] hrst_sync_reg;
	logic [1:0] fdbit_sync_reg;
	logic [1:0] dsel_sync_reg;
	logic [1:0] diag_sync_reg;
	logic       host_rst;
	logic       fd_bit;
	logic       drive_sel;
	logic       diag;

	// Host reset, fixed disk DMA bit, drive select and diagnostic pins pass two flip-flops before use.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hrst_sync_reg  <= 2'h0;
			fdbit_sync_reg <= 2'h0;
			dsel_sync_reg  <= 2'h0;
			diag_sync_reg  <= 2'h0;
		end
		else
		begin
			hrst_sync_reg  <= {hrst_sync_reg[0], host_reset_input};
			fdbit_sync_reg <= {fdbit_sync_reg[0], fixed_disk_dma_bit_in};
			dsel_sync_reg  <= {dsel_sync_reg[0], host_drive_select_in};
			diag_sync_reg  <= {diag_sync_reg[0], host_diag_command_in};
		end
	end

	assign host_rst  = hrst_sync_reg[1];
	assign fd_bit    = fdbit_sync_reg[1];
	assign drive_sel = dsel_sync_reg[1];
	assign diag      = diag_sync_reg[1];

	logic [7:0] misc_reg;
	logic [7:0] xfer_reg;
	logic [3:0] shadow_reg;
	logic [7:0] size_reg;
	logic [7:0] aux_reg;
	logic       ack_reg;
	logic [31:0] rdata_reg;
	logic       access;
	logic       wr;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic       shadow_hit;

	assign access     = wb_cyc_in && wb_stb_in && !ack_reg;
	assign wr         = access && wb_we_in && wb_sel_in[0];
	assign idx        = wb_adr_in[9:2];
	assign wbyte      = wb_dat_in[7:0];
	assign shadow_hit = aux_reg[AUX_SHADOW_SEL] && (idx == IDX_XFER);

	// Every access is answered one cycle after the strobe, unmapped ones too.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ack_reg <= 1'b0;
		else
			ack_reg <= access;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_reg <= 32'h0000_0000;
		else if (access && !wb_we_in)
		begin
			if (shadow_hit)
				rdata_reg <= {28'h0000_000, shadow_reg};
			else
			begin
				unique case (idx)
					IDX_MISC: rdata_reg <= {24'h00_0000, misc_reg};
					IDX_XFER: rdata_reg <= {24'h00_0000, xfer_reg};
					IDX_SIZE: rdata_reg <= {24'h00_0000, size_reg};
					IDX_AUX:  rdata_reg <= {24'h00_0000, aux_reg};
					default:  rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
		else
			rdata_reg <= 32'h0000_0000;
	end

	// Miscellaneous control; bit 5 is a live mirror, bit 6 clears when stop high is written.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			misc_reg <= MISC_RST;
		else
		begin
			if (wr && idx == IDX_MISC)
			begin
				misc_reg[4:0] <= wbyte[4:0];
				misc_reg[MISC_TEST] <= wbyte[MISC_TEST];
			end
			misc_reg[MISC_DMA_MIRROR] <= fd_bit;
			if (stop_high_write_in)
				misc_reg[MISC_STOP_OFF] <= 1'b0;
			else if (wr && idx == IDX_MISC)
				misc_reg[MISC_STOP_OFF] <= wbyte[MISC_STOP_OFF];
		end
	end

	logic done_set;
	logic xfer_clr;

	// three resets clear, demand bit local only
	assign xfer_clr = host_rst || bm_reset_in;

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			xfer_reg <= XFER_RST;
		else
		begin
			if (wr && idx == IDX_XFER && !shadow_hit)
				xfer_reg[XFER_DEMAND] <= wbyte[XFER_DEMAND];
			if (xfer_clr)
			begin
				xfer_reg[6:0] <= 7'h00;
				xfer_reg[XFER_DONE] <= done_set;
			end
			else
			begin
				if (wr && idx == IDX_XFER && !shadow_hit)
				begin
					xfer_reg[1:0] <= wbyte[1:0];
					xfer_reg[6:3] <= wbyte[6:3];
				end
				if (done_set)
					xfer_reg[XFER_DONE] <= 1'b1;
				else if (wr && idx == IDX_XFER && !shadow_hit && wbyte[XFER_START])
					xfer_reg[XFER_DONE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			shadow_reg <= SHD_RST[3:0];
		else if (xfer_clr)
			shadow_reg <= SHD_RST[3:0];
		else if (wr && shadow_hit)
			shadow_reg <= wbyte[3:0] & SHD_MASK;
	end

	// Size changes are not guarded; firmware keeps them away from live transfers.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			size_reg <= SIZE_RST;
			aux_reg  <= AUX_RST;
		end
		else
		begin
			if (wr && idx == IDX_SIZE)
				size_reg <= wbyte;
			if (wr && idx == IDX_AUX)
				aux_reg <= {3'h0, wbyte[4:0]};
		end
	end

	function automatic logic [PTR_W-1:0] seg_mask(input logic [7:0] code, input logic dram);
		int ones;
		int bits;
		ones = 0;
		for (int i = 0; i < 8; i++)
			ones += int'(code[i]);
		if (dram)
			bits = (code == SIZE_ALL) ? DRAM_MAX_BITS : DRAM_BASE_BITS + ones;
		else
			bits = (code == SIZE_NONE) ? SRAM_MAX_BITS : SRAM_BASE_BITS + ones;
		seg_mask = PTR_W'((64'h1 << bits) - 64'h1);
	endfunction

	function automatic logic [PTR_W-1:0] ptr_advance(input logic [PTR_W-1:0] p,
		input logic [PTR_W-1:0] m, input logic var_seg,
		input logic [PTR_W-1:0] s, input logic [PTR_W-1:0] e);
		logic [PTR_W-1:0] inc;
		inc = p + PTR_W'(1);
		if (var_seg)
			ptr_advance = (p == e) ? s : inc;
		else
			ptr_advance = (p & ~m) | (inc & m);
	endfunction

	logic [PTR_W-1:0] mask;
	logic             running;
	logic             compare_on;
	logic [PTR_W-1:0] host_ptr_reg;
	logic [PTR_W-1:0] disk_ptr_reg;

	assign mask       = seg_mask(size_reg, aux_reg[AUX_DRAM]);
	assign running    = xfer_reg[XFER_START] && !xfer_reg[XFER_DONE];
	assign compare_on = !misc_reg[MISC_STOP_OFF];
	assign done_set   = running && compare_on && host_step_in
		&& (host_ptr_reg == stop_pointer_in);

	// The pointer still steps on the final byte, so it reads one past the stop.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			host_ptr_reg <= '0;
		else if (xfer_clr)
			host_ptr_reg <= '0;
		else if (host_auto_command_in)
			host_ptr_reg <= '0;
		else if (host_step_in)
			host_ptr_reg <= ptr_advance(host_ptr_reg, mask, aux_reg[AUX_VAR_SEG],
				buffer_start_in, buffer_end_in);
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			disk_ptr_reg <= '0;
		else if (bm_reset_in)
			disk_ptr_reg <= '0;
		else if (disk_step_in)
			disk_ptr_reg <= ptr_advance(disk_ptr_reg, mask, aux_reg[AUX_VAR_SEG],
				buffer_start_in, buffer_end_in);
	end

	logic dma_gate;
	logic dma_ok;
	logic req_next;
	logic sel_match;

	assign dma_gate = aux_reg[AUX_AT_MODE] && aux_reg[AUX_DMA_MODE]
		&& misc_reg[MISC_DMA_GATE];
	assign dma_ok   = !dma_gate || fd_bit;

	// Without demand mode the request drops for a cycle after every byte.
	always_comb
	begin
		req_next = 1'b0;
		if (running && dma_ok && !done_set)
		begin
			if (xfer_reg[XFER_DEMAND])
				req_next = !host_stall_in;
			else
				req_next = !host_step_in && !host_stall_in;
		end
	end

	assign sel_match = !misc_reg[MISC_MS_EN] || (drive_sel == misc_reg[MISC_MS_SEL]);

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			host_dma_request_out        <= 1'b0;
			host_dma_channel_enable_out <= 1'b0;
			device_selected_out         <= 1'b0;
			status_report_enable_out    <= 1'b0;
		end
		else
		begin
			host_dma_request_out        <= req_next;
			host_dma_channel_enable_out <= dma_ok;
			device_selected_out         <= sel_match || (diag && misc_reg[MISC_MS_EN]);
			status_report_enable_out    <= diag ? !(misc_reg[MISC_MS_EN]
				&& misc_reg[MISC_MS_SEL]) : sel_match;
		end
	end

	logic strobe_on;
	logic chip_on;

	assign strobe_on = xfer_reg[XFER_OUT_EN] || buffer_read_in;
	assign chip_on   = xfer_reg[XFER_CHIP_EN] || uc_buffer_access_in;

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			buffer_output_strobe_n_out      <= 1'b1;
			buffer_chip_select_n_out        <= 1'b1;
			second_buffer_chip_select_n_out <= 1'b1;
			dram_cycle_skip_out             <= 1'b0;
		end
		else
		begin
			buffer_output_strobe_n_out <= !(strobe_on && !misc_reg[MISC_STROBE_OFF]);
			buffer_chip_select_n_out <= !(chip_on
				&& !(xfer_reg[XFER_DUAL_CHIP] && buffer_addr15_in));
			second_buffer_chip_select_n_out <= !(chip_on
				&& xfer_reg[XFER_DUAL_CHIP] && buffer_addr15_in);
			dram_cycle_skip_out <= aux_reg[AUX_DRAM] && misc_reg[MISC_STROBE_OFF]
				&& uc_buffer_access_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			dram_refresh_enable_out          <= 1'b0;
			buffer_parity_enable_out         <= 1'b0;
			host_second_chip_select_mode_out <= 1'b0;
			host_dir_to_host_out             <= 1'b0;
			disk_dir_to_buffer_out           <= 1'b0;
			transfer_done_out                <= 1'b0;
			bm_low_window_out                <= 1'b0;
			bm_high_window_out               <= 1'b0;
			control_store_window_out         <= 1'b0;
		end
		else
		begin
			dram_refresh_enable_out  <= aux_reg[AUX_DRAM] && !shadow_reg[SHD_REFRESH_OFF];
			buffer_parity_enable_out <= aux_reg[AUX_DRAM] && shadow_reg[SHD_PARITY];
			host_second_chip_select_mode_out <= aux_reg[AUX_AT_MODE]
				&& misc_reg[MISC_CS2_MODE];
			host_dir_to_host_out   <= xfer_reg[XFER_HOST_DIR];
			disk_dir_to_buffer_out <= xfer_reg[XFER_DISK_DIR];
			transfer_done_out      <= xfer_reg[XFER_DONE];
			bm_low_window_out        <= !shadow_reg[SHD_OVERLAY];
			bm_high_window_out       <= shadow_reg[SHD_OVERLAY] && !shadow_reg[SHD_FIELD_SEL];
			control_store_window_out <= !shadow_reg[SHD_OVERLAY] || shadow_reg[SHD_FIELD_SEL];
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			host_buffer_pointer_out <= '0;
			disk_buffer_pointer_out <= '0;
		end
		else
		begin
			host_buffer_pointer_out <= host_ptr_reg;
			disk_buffer_pointer_out <= disk_ptr_reg;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;
endmodule
`default_nettype wire

//--- hdl/buf_ctl_pkg.sv
// Constants shared by the buffer manager control block.
`default_nettype none
package buf_ctl_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_MISC     = 8'h52;
	localparam logic [7:0] IDX_XFER     = 8'h53;
	localparam logic [7:0] IDX_SIZE     = 8'h54;
	localparam logic [7:0] IDX_AUX      = 8'h60;
	// Miscellaneous control/status fields.
	localparam int MISC_STROBE_OFF = 0;
	localparam int MISC_MS_EN      = 1;
	localparam int MISC_MS_SEL     = 2;
	localparam int MISC_CS2_MODE   = 3;
	localparam int MISC_DMA_GATE   = 4;
	localparam int MISC_DMA_MIRROR = 5;
	localparam int MISC_STOP_OFF   = 6;
	localparam int MISC_TEST       = 7;
	// Buffer transfer control fields.
	localparam int XFER_DUAL_CHIP  = 0;
	localparam int XFER_START      = 1;
	localparam int XFER_DONE       = 2;
	localparam int XFER_HOST_DIR   = 3;
	localparam int XFER_DISK_DIR   = 4;
	localparam int XFER_CHIP_EN    = 5;
	localparam int XFER_OUT_EN     = 6;
	localparam int XFER_DEMAND     = 7;
	// Buffer mode shadow fields.
	localparam int SHD_OVERLAY     = 0;
	localparam int SHD_FIELD_SEL   = 1;
	localparam int SHD_PARITY      = 2;
	localparam int SHD_REFRESH_OFF = 3;
	// Auxiliary control fields.
	localparam int AUX_VAR_SEG     = 0;
	localparam int AUX_SHADOW_SEL  = 1;
	localparam int AUX_DRAM        = 2;
	localparam int AUX_AT_MODE     = 3;
	localparam int AUX_DMA_MODE    = 4;
	// Reset values.
	localparam logic [7:0] MISC_RST = 8'h00;
	localparam logic [7:0] XFER_RST = 8'h00;
	localparam logic [7:0] SHD_RST  = 8'h00;
	localparam logic [7:0] SIZE_RST = 8'h00;
	localparam logic [7:0] AUX_RST  = 8'h00;
	localparam logic [3:0] SHD_MASK = 4'hF;
	// Size code decode anchors.
	localparam logic [7:0] SIZE_ALL  = 8'hFF;
	localparam logic [7:0] SIZE_NONE = 8'h00;
	localparam int SRAM_BASE_BITS = 8;
	localparam int SRAM_MAX_BITS  = 17;
	localparam int DRAM_BASE_BITS = 13;
	localparam int DRAM_MAX_BITS  = 22;
	localparam int PTR_W          = 22;
endpackage
`default_nettype wire

//--- dv/disk_buffer_manager_control_asserts.sv
// Port checker for the buffer manager control block.
`default_nettype none
module disk_buffer_manager_control_checker
	import buf_ctl_pkg::*;
(
	input wire logic             mclk_in,
	input wire logic             rst_n_in,
	input wire logic             wb_cyc_in,
	input wire logic             wb_stb_in,
	input wire logic             wb_we_in,
	input wire logic [9:0]       wb_adr_in,
	input wire logic [3:0]       wb_sel_in,
	input wire logic [31:0]      wb_dat_in,
	input wire logic [31:0]      wb_dat_out,
	input wire logic             wb_ack_out,
	input wire logic             host_reset_input,
	input wire logic             bm_reset_in,
	input wire logic             host_stall_in,
	input wire logic             host_auto_command_in,
	input wire logic             buffer_output_strobe_n_out,
	input wire logic             buffer_chip_select_n_out,
	input wire logic             host_dma_request_out,
	input wire logic             host_dir_to_host_out,
	input wire logic             disk_dir_to_buffer_out,
	input wire logic [PTR_W-1:0] host_buffer_pointer_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       wr;
	logic       off_reg;
	logic       sel_reg;
	logic [7:0] xfer_reg;
	logic [7:0] xd_reg;
	logic       od_reg;
	logic [2:0] quiet_reg;
	assign wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			off_reg <= 1'b0;
		else if (wr && wb_adr_in[9:2] == IDX_MISC)
			off_reg <= wb_dat_in[MISC_STROBE_OFF];
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			sel_reg <= 1'b0;
		else if (wr && wb_adr_in[9:2] == IDX_AUX)
			sel_reg <= wb_dat_in[AUX_SHADOW_SEL];
	// Clearing on the raw host reset runs ahead of the design's synchroniser.
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			xfer_reg <= 8'h00;
		else if (host_reset_input || bm_reset_in)
			xfer_reg[6:0] <= 7'h00;
		else if (wr && wb_adr_in[9:2] == IDX_XFER && !sel_reg)
			xfer_reg <= wb_dat_in[7:0];
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			xd_reg <= 8'h00;
			od_reg <= 1'b0;
		end
		else
		begin
			xd_reg <= xfer_reg;
			od_reg <= off_reg;
		end
	// Checks that follow the copy wait until a host reset has long settled.
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			quiet_reg <= 3'h0;
		else if (host_reset_input)
			quiet_reg <= 3'h0;
		else if (quiet_reg != 3'h7)
			quiet_reg <= quiet_reg + 3'h1;
	default clocking dc @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	property p_strobe_off;
		od_reg |-> buffer_output_strobe_n_out;
	endproperty
	a_strobe_off: assert property (p_strobe_off) else $error("strobe low while suppressed");
	property p_out_en;
		xd_reg[XFER_OUT_EN] && !od_reg && quiet_reg == 3'h7 |-> !buffer_output_strobe_n_out;
	endproperty
	a_out_en: assert property (p_out_en) else $error("strobe not asserted");
	property p_chip_en;
		xd_reg[XFER_CHIP_EN] && !xd_reg[XFER_DUAL_CHIP] && quiet_reg == 3'h7
			|-> !buffer_chip_select_n_out;
	endproperty
	a_chip_en: assert property (p_chip_en) else $error("chip select not held");
	property p_xfer_rd;
		wb_ack_out && !wb_we_in && wb_adr_in[9:2] == IDX_XFER && !sel_reg && quiet_reg == 3'h7
			|-> (wb_dat_out[7:0] & 8'hFB) == (xd_reg & 8'hFB);
	endproperty
	a_xfer_rd: assert property (p_xfer_rd) else $error("transfer control readback");
	property p_host_dir;
		quiet_reg == 3'h7 |-> host_dir_to_host_out == xd_reg[XFER_HOST_DIR];
	endproperty
	a_host_dir: assert property (p_host_dir) else $error("host direction wrong");
	property p_disk_dir;
		quiet_reg == 3'h7 |-> disk_dir_to_buffer_out == xd_reg[XFER_DISK_DIR];
	endproperty
	a_disk_dir: assert property (p_disk_dir) else $error("disk direction wrong");
	property p_stall;
		host_stall_in |=> !host_dma_request_out;
	endproperty
	a_stall: assert property (p_stall) else $error("request kept during stall");
	property p_auto;
		host_auto_command_in |-> ##2 host_buffer_pointer_out == '0;
	endproperty
	a_auto: assert property (p_auto) else $error("host pointer not zeroed");
	c_write: cover property (wr);
	c_request: cover property (host_dma_request_out);
	c_strobe: cover property (!buffer_output_strobe_n_out);
endmodule
bind disk_buffer_manager_control disk_buffer_manager_control_checker u_checker (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .host_reset_input(host_reset_input),
	.bm_reset_in(bm_reset_in), .host_stall_in(host_stall_in),
	.host_auto_command_in(host_auto_command_in),
	.buffer_output_strobe_n_out(buffer_output_strobe_n_out),
	.buffer_chip_select_n_out(buffer_chip_select_n_out),
	.host_dma_request_out(host_dma_request_out), .host_dir_to_host_out(host_dir_to_host_out),
	.disk_dir_to_buffer_out(disk_dir_to_buffer_out),
	.host_buffer_pointer_out(host_buffer_pointer_out));
`default_nettype wire

//--- dv/host_bus_model.sv
// Host bus side that answers DMA requests with byte strobes.
`default_nettype none
module host_bus_model
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic request_in,
	input  wire logic slow_in,
	output logic      step_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] gap_reg;
	// bytes move only while requested; slow mode spaces them four apart.
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			gap_reg  <= 2'h0;
			step_out <= 1'b0;
		end
		else
		begin
			gap_reg  <= gap_reg + 2'h1;
			step_out <= request_in && !step_out && (!slow_in || gap_reg == 2'h0);
		end
endmodule
`default_nettype wire

//--- dv/disk_buffer_manager_control_tb.sv
// Self-checking bench for the buffer manager control block.
`default_nettype none
module disk_buffer_manager_control_tb
	import buf_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, hrst = 1'b0;
	logic bmr = 1'b0, fdb = 1'b0, dsel = 1'b0, diag = 1'b0, hauto = 1'b0, stall = 1'b0;
	logic dstep = 1'b0, uca = 1'b0, brd = 1'b0, a15 = 1'b0, shw = 1'b0, slow = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic [21:0] stop = 22'h000000, bst = 22'h000000, bend = 22'h000000;
	logic [31:0] dout;
	logic [21:0] hptr, dptr;
	logic [7:0]  rd;
	logic ack, strb_n, cs_n, cs2_n, skip, refr, par, dsl, rpt, hcs2, dmae, dreq, hdir;
	logic ddir, done, wlo, whi, formatter_control_store, hstep;
	int fails = 0;
	int compares = 0;
	always #2.5 clk = ~clk;
	disk_buffer_manager_control u_disk_buffer_manager_control (
		.mclk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack),
		.host_reset_input(hrst), .bm_reset_in(bmr), .fixed_disk_dma_bit_in(fdb),
		.host_drive_select_in(dsel), .host_diag_command_in(diag), .host_auto_command_in(hauto),
		.host_step_in(hstep), .host_stall_in(stall), .disk_step_in(dstep),
		.uc_buffer_access_in(uca), .buffer_read_in(brd), .buffer_addr15_in(a15),
		.stop_high_write_in(shw), .stop_pointer_in(stop), .buffer_start_in(bst),
		.buffer_end_in(bend), .buffer_output_strobe_n_out(strb_n), .buffer_chip_select_n_out(cs_n),
		.second_buffer_chip_select_n_out(cs2_n), .dram_cycle_skip_out(skip),
		.dram_refresh_enable_out(refr), .buffer_parity_enable_out(par),
		.device_selected_out(dsl), .status_report_enable_out(rpt),
		.host_second_chip_select_mode_out(hcs2), .host_dma_channel_enable_out(dmae),
		.host_dma_request_out(dreq), .host_dir_to_host_out(hdir), .disk_dir_to_buffer_out(ddir),
		.transfer_done_out(done), .bm_low_window_out(wlo), .bm_high_window_out(whi),
		.control_store_window_out(formatter_control_store), .host_buffer_pointer_out(hptr),
		.disk_buffer_pointer_out(dptr));
	host_bus_model u_host_bus_model (.clk_in(clk), .rst_n_in(rst_n), .request_in(dreq),
		.slow_in(slow), .step_out(hstep));
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// The request is held until ack is sampled, then released for a cycle.
	task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= 4'h1;
		adr <= {idx, 2'b00};
		dat <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		rd = dout[7:0];
		if (ack !== 1'b1)
			fails++;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e, input string nm);
		wb(idx, 1'b0, 8'h00);
		chk(nm, e, rd);
	endtask
	task automatic hreset();
		@(posedge clk);
		hrst <= 1'b1;
		wt(4);
		hrst <= 1'b0;
		wt(8);
	endtask
	task automatic bmpulse();
		@(posedge clk);
		bmr <= 1'b1;
		@(posedge clk);
		bmr <= 1'b0;
		wt(2);
	endtask
	task automatic dsteps(input int n);
		repeat (n)
		begin
			@(posedge clk);
			dstep <= 1'b1;
			@(posedge clk);
			dstep <= 1'b0;
		end
		wt(2);
	endtask
	task automatic waitdone();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		wt(2);
		chk("done", 1'b1, done);
	endtask
	task automatic role(input logic [7:0] m, input logic s, input logic g, input logic [1:0] e);
		wb(IDX_MISC, 1'b1, m);
		dsel <= s;
		diag <= g;
		wt(6);
		chk("role", e, {dsl, rpt});
	endtask
	task automatic t_regs();
		rdchk(IDX_XFER, 8'h00, "xfer");
		rdchk(IDX_SIZE, 8'h00, "size");
		rdchk(8'h10, 8'h00, "unmapped");
		wb(IDX_SIZE, 1'b1, 8'hFF);
		rdchk(IDX_SIZE, 8'hFF, "size_rw");
		wb(IDX_MISC, 1'b1, 8'h40);
		rdchk(IDX_MISC, 8'h40, "stop_off");
		shw <= 1'b1;
		@(posedge clk);
		shw <= 1'b0;
		rdchk(IDX_MISC, 8'h00, "stop_on");
	endtask
	task automatic t_mem();
		logic [1:0] cd [3] = '{2'h0, 2'h1, 2'h3};
		logic [2:0] ex [3] = '{3'h5, 3'h2, 3'h1};
		wb(IDX_XFER, 1'b1, 8'hC0);
		wt(2);
		chk("oe", 1'b0, strb_n);
		wb(IDX_MISC, 1'b1, 8'h01);
		wb(IDX_AUX, 1'b1, 8'h06);
		uca <= 1'b1;
		wt(2);
		chk("oe_off", 1'b1, strb_n);
		chk("skip", 1'b1, skip);
		chk("refresh", 1'b1, refr);
		wb(IDX_XFER, 1'b1, 8'h0C);
		wt(2);
		chk("par_ref", 2'b10, {par, refr});
		for (int i = 0; i < 3; i++)
		begin
			wb(IDX_XFER, 1'b1, {6'h00, cd[i]});
			wt(2);
			chk("map", ex[i], {wlo, whi, formatter_control_store});
		end
		hreset();
		rdchk(IDX_XFER, 8'h00, "shadow");
		wb(IDX_AUX, 1'b1, 8'h00);
		rdchk(IDX_XFER, 8'h80, "xfer_hrst");
		wb(IDX_XFER, 1'b1, 8'hC0);
		bmpulse();
		rdchk(IDX_XFER, 8'h80, "xfer_bmr");
		wb(IDX_MISC, 1'b1, 8'h00);
		uca <= 1'b0;
		wb(IDX_XFER, 1'b1, 8'h20);
		wt(2);
		chk("ce", 2'b01, {cs_n, cs2_n});
		wb(IDX_XFER, 1'b1, 8'h01);
		uca <= 1'b1;
		a15 <= 1'b1;
		wt(2);
		chk("ce2", 2'b10, {cs_n, cs2_n});
		a15 <= 1'b0;
		wt(2);
		chk("ce1", 2'b01, {cs_n, cs2_n});
		uca <= 1'b0;
		brd <= 1'b1;
		wt(2);
		chk("rd_oe", 1'b0, strb_n);
		brd <= 1'b0;
		wb(IDX_XFER, 1'b1, 8'h00);
	endtask
	task automatic t_host();
		role(8'h02, 1'b0, 1'b0, 2'b11);
		role(8'h02, 1'b1, 1'b0, 2'b00);
		role(8'h06, 1'b1, 1'b0, 2'b11);
		role(8'h06, 1'b0, 1'b0, 2'b00);
		role(8'h06, 1'b0, 1'b1, 2'b10);
		role(8'h02, 1'b1, 1'b1, 2'b11);
		wb(IDX_AUX, 1'b1, 8'h08);
		role(8'h08, 1'b0, 1'b0, 2'b11);
		chk("cs2_mode", 1'b1, hcs2);
		fdb <= 1'b1;
		wt(6);
		rdchk(IDX_MISC, 8'h28, "mirror");
		wb(IDX_MISC, 1'b1, 8'h10);
		wb(IDX_AUX, 1'b1, 8'h18);
		wt(2);
		chk("gate_on", 1'b1, dmae);
		fdb <= 1'b0;
		wt(6);
		chk("gate_off", 1'b0, dmae);
		wb(IDX_AUX, 1'b1, 8'h00);
		wb(IDX_MISC, 1'b1, 8'h00);
	endtask
	task automatic t_xfer();
		stop <= 22'h000005;
		hauto <= 1'b1;
		@(posedge clk);
		hauto <= 1'b0;
		wb(IDX_XFER, 1'b1, 8'h0A);
		waitdone();
		chk("hptr", 22'h000006, hptr);
		chk("hdir", 1'b1, hdir);
		rdchk(IDX_XFER, 8'h0E, "xfer_done");
		slow <= 1'b1;
		stop <= 22'h00000A;
		wb(IDX_XFER, 1'b1, 8'h82);
		wt(3);
		chk("dreq", 1'b1, dreq);
		chk("hdir_in", 1'b0, hdir);
		stall <= 1'b1;
		wt(2);
		chk("dreq_stall", 1'b0, dreq);
		stall <= 1'b0;
		waitdone();
		chk("hptr2", 22'h00000B, hptr);
	endtask
	task automatic t_wrap();
		wb(IDX_SIZE, 1'b1, 8'h0F);
		wb(IDX_XFER, 1'b1, 8'h10);
		wt(2);
		chk("ddir", 1'b1, ddir);
		bmpulse();
		dsteps(4095);
		chk("seg_top", 22'h000FFF, dptr);
		dsteps(1);
		chk("seg_wrap", 22'h000000, dptr);
		wb(IDX_AUX, 1'b1, 8'h01);
		bst <= 22'h000010;
		bend <= 22'h000020;
		bmpulse();
		dsteps(33);
		chk("var_wrap", 22'h000010, dptr);
	endtask
	initial
	begin
		wt(4);
		rst_n <= 1'b1;
		t_regs();
		t_mem();
		t_host();
		t_xfer();
		t_wrap();
		results();
	end
	initial
	begin
		wt(40000);
		fails++;
		results();
	end
endmodule
`default_nettype wire
